/* cnp_pkg.sv */
// Constants, states and register map of the configuration memory programming block.
package cnp_pkg;
	localparam logic [6:0] I2C_ADDR     = 7'h10;
	localparam logic [7:0] REG_FIRST    = 8'h01;
	localparam logic [7:0] REG_LAST     = 8'h0A;
	localparam logic [7:0] REG_KEY      = 8'h0B;
	localparam logic [7:0] KEY_UNLOCK   = 8'h41;
	localparam logic [7:0] KEY_PREREAD  = 8'h62;
	localparam logic [7:0] KEY_RESET    = 8'h00;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [7:0] PTR_STEP     = 8'h01;
	localparam logic [3:0] LOC_BASE     = 4'h1;
	localparam int         NVM_LOCS     = 10;
	localparam logic [2:0] BIT_FIRST    = 3'h0;
	localparam logic [2:0] BIT_STEP     = 3'h1;
	localparam logic [2:0] BIT_LAST     = 3'h7;
	localparam logic [7:0] TRIM_DEFAULT = 8'h00;
	// Synchroniser reset order: commit, enable, data, clock.
	localparam logic [3:0] SYNC_RST     = 4'h3;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_PTR,
		ST_ACK_PTR,
		ST_WDATA,
		ST_ACK_WDATA,
		ST_RDATA,
		ST_RACK
	} cnp_state_t;
endpackage

/* cnp_pin_sync.sv */
// Three-stage pin synchroniser with a two-stage agreement filter.
`timescale 1ns/1ps
module cnp_pin_sync
	import cnp_pkg::*;
#(
	parameter int             W       = 4,
	parameter logic [W-1:0]   RST_VAL = '0
)
(
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// Pins and filtered levels
	input  wire logic [W-1:0]  i_pins,
	output logic      [W-1:0]  o_level
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] level_ff;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s1_ff    <= RST_VAL;
			s2_ff    <= RST_VAL;
			s3_ff    <= RST_VAL;
			level_ff <= RST_VAL;
		end
		else
		begin
			s1_ff    <= i_pins;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			// A bit changes only once the second and third stages agree.
			level_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & level_ff);
		end
	end

	assign o_level = level_ff;
endmodule

/* cnp_config_nvm.sv */
// Serial register slave, commit control and parity-guarded configuration store.
`timescale 1ns/1ps
module cnp_config_nvm
	import cnp_pkg::*;
#(
	parameter logic [7:0] TRIM_DATA = TRIM_DEFAULT
)
(
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// Serial port pins
	input  wire logic                  i_serial_port_enable_pin,
	input  wire logic                  i_scl,
	input  wire logic                  i_sda,
	output logic                       o_sda_out,
	output logic                       o_sda_oe_n,
	// Commit pin and storage disturbance
	input  wire logic                  i_commit_pin,
	input  wire logic                  i_nvm_disturb,
	// Switch drive requests and outputs
	input  wire logic                  i_discharge_request,
	input  wire logic                  i_charge_request,
	output logic                       o_discharge_switch_drive,
	output logic                       o_charge_switch_drive,
	output logic                       o_parity_fault,
	// Stored configuration, location 0x01 in the low byte
	output logic [8*NVM_LOCS-1:0]      o_stored_config
);
	logic [3:0]  lvl;
	logic        scl_f;
	logic        sda_f;
	logic        en_f;
	logic        commit_f;
	logic        scl_q_ff;
	logic        sda_q_ff;
	logic        commit_q_ff;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        commit_now;

	cnp_state_t  state_ff;
	logic [7:0]  shift_ff;
	logic [7:0]  tx_ff;
	logic [2:0]  cnt_ff;
	logic        done_ff;
	logic        rw_ff;
	logic        more_ff;
	logic [7:0]  ptr_ff;
	logic        sda_oe_n_ff;
	logic        sda_out_ff;
	logic        wr_pulse_ff;
	logic [7:0]  wr_addr_ff;
	logic [7:0]  wr_data_ff;

	logic [7:0]  cfg_ff [0:NVM_LOCS-1];
	logic [7:0]  nvm_ff [0:NVM_LOCS-1];
	logic [7:0]  key_ff;
	logic [7:0]  trim_ff;
	logic [7:0]  parity_ff;
	logic [7:0]  nvm_par;
	logic [7:0]  cfg_par;
	logic        mismatch;
	logic [7:0]  rd_byte;
	logic [3:0]  rd_idx;
	logic [3:0]  wr_idx;
	logic        dsg_ff;
	logic        chg_ff;
	logic        fault_ff;

	cnp_pin_sync #(
		.W       (4),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_pins  ({i_commit_pin, i_serial_port_enable_pin, i_sda, i_scl}),
		.o_level (lvl)
	);

	assign scl_f    = lvl[0];
	assign sda_f    = lvl[1];
	assign en_f     = lvl[2];
	assign commit_f = lvl[3];

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			scl_q_ff    <= 1'b1;
			sda_q_ff    <= 1'b1;
			commit_q_ff <= 1'b0;
		end
		else
		begin
			scl_q_ff    <= scl_f;
			sda_q_ff    <= sda_f;
			commit_q_ff <= commit_f;
		end
	end

	assign scl_rise   = scl_f & ~scl_q_ff;
	assign scl_fall   = ~scl_f & scl_q_ff;
	assign start_det  = scl_f & scl_q_ff & sda_q_ff & ~sda_f;
	assign stop_det   = scl_f & scl_q_ff & ~sda_q_ff & sda_f;
	// Data is stored on the falling edge of a high-then-low commit pulse.
	assign commit_now = commit_q_ff & ~commit_f;

	assign rd_idx = 4'(ptr_ff[3:0] - LOC_BASE);
	assign wr_idx = 4'(wr_addr_ff[3:0] - LOC_BASE);

	always_comb
	begin
		rd_byte = BYTE_ZERO;
		if (ptr_ff >= REG_FIRST && ptr_ff <= REG_LAST)
			rd_byte = (key_ff == KEY_PREREAD) ? nvm_ff[rd_idx] : cfg_ff[rd_idx];
		else if (ptr_ff == REG_KEY)
			rd_byte = key_ff;
	end

	// Serial slave; the whole port is held idle while the enable pin is low.
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !en_f)
		begin
			state_ff    <= ST_IDLE;
			shift_ff    <= BYTE_ZERO;
			tx_ff       <= BYTE_ZERO;
			cnt_ff      <= BIT_FIRST;
			done_ff     <= 1'b0;
			rw_ff       <= 1'b0;
			more_ff     <= 1'b0;
			ptr_ff      <= BYTE_ZERO;
			sda_oe_n_ff <= 1'b1;
			wr_pulse_ff <= 1'b0;
			wr_addr_ff  <= BYTE_ZERO;
			wr_data_ff  <= BYTE_ZERO;
		end
		else
		begin
			wr_pulse_ff <= 1'b0;
			if (start_det)
			begin
				state_ff    <= ST_ADDR;
				cnt_ff      <= BIT_FIRST;
				done_ff     <= 1'b0;
				sda_oe_n_ff <= 1'b1;
			end
			else if (stop_det)
			begin
				state_ff    <= ST_IDLE;
				done_ff     <= 1'b0;
				sda_oe_n_ff <= 1'b1;
			end
			else
			begin
				case (state_ff)
					ST_ADDR, ST_PTR, ST_WDATA:
					begin
						if (scl_rise)
						begin
							shift_ff <= {shift_ff[6:0], sda_f};
							cnt_ff   <= 3'(cnt_ff + BIT_STEP);
							if (cnt_ff == BIT_LAST)
								done_ff <= 1'b1;
						end
						else if (scl_fall && done_ff)
						begin
							done_ff     <= 1'b0;
							cnt_ff      <= BIT_FIRST;
							sda_oe_n_ff <= 1'b0;
							if (state_ff == ST_ADDR)
							begin
								if (shift_ff[7:1] == I2C_ADDR)
								begin
									rw_ff    <= shift_ff[0];
									state_ff <= ST_ACK_ADDR;
								end
								else
								begin
									sda_oe_n_ff <= 1'b1;
									state_ff    <= ST_IDLE;
								end
							end
							else if (state_ff == ST_PTR)
							begin
								ptr_ff   <= shift_ff;
								state_ff <= ST_ACK_PTR;
							end
							else
							begin
								wr_pulse_ff <= 1'b1;
								wr_addr_ff  <= ptr_ff;
								wr_data_ff  <= shift_ff;
								ptr_ff      <= 8'(ptr_ff + PTR_STEP);
								state_ff    <= ST_ACK_WDATA;
							end
						end
					end
					ST_ACK_ADDR:
					begin
						if (scl_fall)
						begin
							if (rw_ff)
							begin
								tx_ff       <= rd_byte;
								sda_oe_n_ff <= rd_byte[7];
								state_ff    <= ST_RDATA;
							end
							else
							begin
								sda_oe_n_ff <= 1'b1;
								state_ff    <= ST_PTR;
							end
						end
					end
					ST_ACK_PTR, ST_ACK_WDATA:
					begin
						if (scl_fall)
						begin
							sda_oe_n_ff <= 1'b1;
							state_ff    <= ST_WDATA;
						end
					end
					ST_RDATA:
					begin
						if (scl_rise)
						begin
							cnt_ff <= 3'(cnt_ff + BIT_STEP);
							if (cnt_ff == BIT_LAST)
								done_ff <= 1'b1;
						end
						else if (scl_fall)
						begin
							if (done_ff)
							begin
								done_ff     <= 1'b0;
								cnt_ff      <= BIT_FIRST;
								sda_oe_n_ff <= 1'b1;
								ptr_ff      <= 8'(ptr_ff + PTR_STEP);
								state_ff    <= ST_RACK;
							end
							else
							begin
								tx_ff       <= {tx_ff[6:0], 1'b0};
								sda_oe_n_ff <= tx_ff[6];
							end
						end
					end
					ST_RACK:
					begin
						if (scl_rise)
							more_ff <= ~sda_f;
						else if (scl_fall)
						begin
							if (more_ff)
							begin
								tx_ff       <= rd_byte;
								sda_oe_n_ff <= rd_byte[7];
								state_ff    <= ST_RDATA;
							end
							else
								state_ff <= ST_IDLE;
						end
					end
					ST_IDLE:
						state_ff <= ST_IDLE;
					default:
						state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// Configuration and key registers.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < NVM_LOCS; i++)
				cfg_ff[i] <= BYTE_ZERO;
			key_ff <= KEY_RESET;
		end
		else if (wr_pulse_ff)
		begin
			if (wr_addr_ff >= REG_FIRST && wr_addr_ff <= REG_LAST)
				cfg_ff[wr_idx] <= wr_data_ff;
			else if (wr_addr_ff == REG_KEY)
				key_ff <= wr_data_ff;
		end
	end

	always_comb
	begin
		nvm_par = trim_ff;
		cfg_par = trim_ff;
		for (int i = 0; i < NVM_LOCS; i++)
		begin
			nvm_par = nvm_par ^ nvm_ff[i];
			cfg_par = cfg_par ^ cfg_ff[i];
		end
	end

	assign mismatch = (nvm_par != parity_ff);

	// Store; the disturbance input flips one stored bit to model a failing cell.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < NVM_LOCS; i++)
				nvm_ff[i] <= BYTE_ZERO;
			trim_ff   <= TRIM_DATA;
			parity_ff <= TRIM_DATA;
		end
		else
		begin
			if (commit_now && key_ff == KEY_UNLOCK)
			begin
				for (int i = 0; i < NVM_LOCS; i++)
					nvm_ff[i] <= cfg_ff[i];
				parity_ff <= cfg_par;
			end
			if (i_nvm_disturb)
				nvm_ff[0][0] <= ~nvm_ff[0][0];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			dsg_ff     <= 1'b0;
			chg_ff     <= 1'b0;
			fault_ff   <= 1'b0;
			sda_out_ff <= 1'b0;
		end
		else
		begin
			dsg_ff     <= i_discharge_request & ~mismatch;
			chg_ff     <= i_charge_request & ~mismatch;
			fault_ff   <= mismatch;
			sda_out_ff <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NVM_LOCS; g++)
		begin : g_flat
			assign o_stored_config[8*g +: 8] = nvm_ff[g];
		end
	endgenerate

	assign o_sda_out                = sda_out_ff;
	assign o_sda_oe_n               = sda_oe_n_ff;
	assign o_discharge_switch_drive = dsg_ff;
	assign o_charge_switch_drive    = chg_ff;
	assign o_parity_fault           = fault_ff;

	property p_commit_copies;
		@(posedge i_clk) disable iff (i_rst)
		commit_now && key_ff == KEY_UNLOCK && !i_nvm_disturb
		|=> nvm_ff[0] == $past(cfg_ff[0]) && nvm_ff[NVM_LOCS-1] == $past(cfg_ff[NVM_LOCS-1]);
	endproperty
	a_commit_copies: assert property (p_commit_copies) else $error("commit did not copy");

	property p_locked_commit;
		@(posedge i_clk) disable iff (i_rst)
		commit_now && key_ff != KEY_UNLOCK && !i_nvm_disturb
		|=> $stable(parity_ff) && nvm_ff[0] == $past(nvm_ff[0]);
	endproperty
	a_locked_commit: assert property (p_locked_commit) else $error("locked commit changed");

	property p_preread;
		@(posedge i_clk) disable iff (i_rst)
		key_ff == KEY_PREREAD && ptr_ff == REG_FIRST |-> rd_byte == nvm_ff[0];
	endproperty
	a_preread: assert property (p_preread) else $error("pre-read shows wrong byte");

	property p_key_reset;
		@(posedge i_clk)
		i_rst |=> key_ff == KEY_RESET && !o_discharge_switch_drive;
	endproperty
	a_key_reset: assert property (p_key_reset) else $error("key not cleared by reset");

	property p_key_write;
		@(posedge i_clk) disable iff (i_rst)
		wr_pulse_ff && wr_addr_ff == REG_KEY |=> key_ff == $past(wr_data_ff);
	endproperty
	a_key_write: assert property (p_key_write) else $error("key write lost");

	property p_port_disabled;
		@(posedge i_clk) disable iff (i_rst)
		!en_f |=> o_sda_oe_n && state_ff == ST_IDLE && !wr_pulse_ff;
	endproperty
	a_port_disabled: assert property (p_port_disabled) else $error("port active while off");

	property p_parity_kept;
		@(posedge i_clk) disable iff (i_rst)
		commit_now && key_ff == KEY_UNLOCK && !i_nvm_disturb |=> !mismatch ##1 !o_parity_fault;
	endproperty
	a_parity_kept: assert property (p_parity_kept) else $error("parity wrong after commit");

	property p_failsafe;
		@(posedge i_clk) disable iff (i_rst)
		mismatch |=> !o_discharge_switch_drive && !o_charge_switch_drive && o_parity_fault;
	endproperty
	a_failsafe: assert property (p_failsafe) else $error("drives on with parity error");
endmodule

/* cnp_host_model.sv */
// Serial host model that writes and reads the configuration registers.
`timescale 1ns/1ps
module cnp_host_model
	import cnp_pkg::*;
#(
	parameter int HALF = 10
)
(
	// Clock and resolved data line
	input  wire logic i_clk,
	input  wire logic i_sda,
	// Host drives, pull high means data held low
	output logic      o_scl,
	output logic      o_sda_pull
);
	initial
	begin
		o_scl      = 1'b1;
		o_sda_pull = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// Data moves two clocks after the clock falls, so it never crosses a high clock.
	// A start waits half a period first, so a slave still acknowledging lets go of the data line.
	task automatic start;
		o_sda_pull <= 1'b0;
		wt(HALF);
		o_scl <= 1'b1;
		wt(HALF);
		o_sda_pull <= 1'b1;
		wt(HALF);
		o_scl <= 1'b0;
		wt(2);
	endtask

	task automatic stop;
		o_sda_pull <= 1'b1;
		wt(2);
		o_scl <= 1'b1;
		wt(HALF);
		o_sda_pull <= 1'b0;
		wt(HALF);
	endtask

	task automatic bitx(input logic b, output logic r);
		o_sda_pull <= ~b;
		wt(HALF);
		o_scl <= 1'b1;
		wt(HALF);
		r = i_sda;
		o_scl <= 1'b0;
		wt(2);
	endtask

	task automatic wbyte(input logic [7:0] b, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], r);
		bitx(1'b1, r);
		ok = ok & (r === 1'b0);
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$], output logic ok);
		ok = 1'b1;
		start();
		wbyte({I2C_ADDR, 1'b0}, ok);
		wbyte(ptr, ok);
		foreach (d[k])
			wbyte(d[k], ok);
		stop();
	endtask

	task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic r;
		ok = 1'b1;
		start();
		wbyte({I2C_ADDR, 1'b0}, ok);
		wbyte(ptr, ok);
		start();
		wbyte({I2C_ADDR, 1'b1}, ok);
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(1'b1, r);
		stop();
	endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the configuration memory programming block.
`timescale 1ns/1ps
module tb_top
	import cnp_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        en = 1'b1;
	logic        commit = 1'b0;
	logic        disturb = 1'b0;
	logic        req = 1'b1;
	logic        scl, pull, sda_out, sda_oe_n, discharge_switch_drive, charge_switch_drive, fault, ok;
	logic [79:0] stored, exp_cfg;
	logic [7:0]  rv;
	logic [7:0]  cfg [$];
	int          miscompares = 0;
	int          total_checks = 0;
	wire         sda_line = ~(pull | (~sda_oe_n & ~sda_out));

	always #4 clk = ~clk;

	cnp_config_nvm cnp_config_nvm_inst (
		.i_clk(clk), .i_rst(rst), .i_serial_port_enable_pin(en), .i_scl(scl),
		.i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
		.i_commit_pin(commit), .i_nvm_disturb(disturb), .i_discharge_request(req),
		.i_charge_request(req), .o_discharge_switch_drive(discharge_switch_drive),
		.o_charge_switch_drive(charge_switch_drive), .o_parity_fault(fault), .o_stored_config(stored)
	);

	cnp_host_model cnp_host_model_inst (
		.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda_pull(pull)
	);

	task automatic check(input logic [79:0] seen, input logic [79:0] want);
		total_checks++;
		if (seen !== want)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic pulse_commit;
		commit <= 1'b1;
		repeat (10) @(posedge clk);
		commit <= 1'b0;
		repeat (10) @(posedge clk);
	endtask

	task automatic put(input logic [7:0] ptr, input logic [7:0] v, input logic want_ok);
		cfg = {v};
		cnp_host_model_inst.wr(ptr, cfg, ok);
		check(80'(ok), 80'(want_ok));
	endtask

	task automatic get(input logic [7:0] ptr, input logic [7:0] want);
		cnp_host_model_inst.rd(ptr, rv, ok);
		check(80'({ok, rv}), 80'({1'b1, want}));
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		give_verdict();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		get(REG_KEY, KEY_RESET);
		check(stored, 80'h0);
		cfg = {};
		for (int i = 1; i <= NVM_LOCS; i++)
		begin
			cfg.push_back(8'hA0 | 8'(i));
			exp_cfg[8*(i-1)+:8] = 8'hA0 | 8'(i);
		end
		cnp_host_model_inst.wr(REG_FIRST, cfg, ok);
		check(80'(ok), 80'h1);
		pulse_commit();
		check(stored, 80'h0);
		put(REG_KEY, KEY_UNLOCK, 1'b1);
		get(REG_KEY, KEY_UNLOCK);
		pulse_commit();
		check(stored, exp_cfg);
		check(80'({discharge_switch_drive, charge_switch_drive, fault}), 80'h6);
		put(REG_FIRST, 8'h55, 1'b1);
		put(REG_KEY, KEY_PREREAD, 1'b1);
		get(REG_FIRST, 8'hA1);
		get(8'h0A, 8'hAA);
		get(8'h0C, BYTE_ZERO);
		put(REG_KEY, KEY_RESET, 1'b1);
		get(REG_FIRST, 8'h55);
		pulse_commit();
		check(stored, exp_cfg);
		en <= 1'b0;
		repeat (10) @(posedge clk);
		put(REG_KEY, KEY_UNLOCK, 1'b0);
		en <= 1'b1;
		repeat (10) @(posedge clk);
		get(REG_KEY, KEY_RESET);
		put(REG_KEY, KEY_UNLOCK, 1'b1);
		disturb <= 1'b1;
		@(posedge clk);
		disturb <= 1'b0;
		for (int n = 0; n < 10 && fault !== 1'b1; n++)
			@(posedge clk);
		@(negedge clk);
		if (fault !== 1'b1)
		begin
			miscompares++;
			give_verdict();
		end
		check(80'({discharge_switch_drive, charge_switch_drive, fault}), 80'h1);
		check(stored, exp_cfg ^ 80'h1);
		@(posedge clk);
		pulse_commit();
		exp_cfg[7:0] = 8'h55;
		check(stored, exp_cfg);
		check(80'({discharge_switch_drive, charge_switch_drive, fault}), 80'h6);
		req <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(80'({discharge_switch_drive, charge_switch_drive, fault}), 80'h0);
		give_verdict();
	end
endmodule
